// ### core/dur_pkg.sv
// Shared constants and types for the dual channel register select block.
// Assumes one core clock; host bus pins are asynchronous to it.
package dur_pkg;
  // Register addresses within a channel
  localparam logic [2:0] DUR_A_0 = 3'h0;
  localparam logic [2:0] DUR_A_1 = 3'h1;
  localparam logic [2:0] DUR_A_2 = 3'h2;
  localparam logic [2:0] DUR_A_3 = 3'h3;
  localparam logic [2:0] DUR_A_4 = 3'h4;
  localparam logic [2:0] DUR_A_5 = 3'h5;
  localparam logic [2:0] DUR_A_6 = 3'h6;
  localparam logic [2:0] DUR_A_7 = 3'h7;
  // Bank keys and field positions
  localparam logic [7:0] DUR_LC_ENH_KEY  = 8'hbf;
  localparam int         DUR_LC_DIV_BIT  = 7;
  localparam int         DUR_FT_SWAP_BIT = 6;
  localparam int         DUR_FT_MODE_BIT = 7;
  localparam int         DUR_AF_CONC_BIT = 0;
  localparam int         DUR_RX_CLR_BIT  = 1;
  localparam int         DUR_TX_CLR_BIT  = 2;
  localparam int         DUR_CHANNELS    = 2;
  localparam logic [6:0] DUR_FIFO_DEPTH  = 7'h40;
  localparam logic [6:0] DUR_LVL_ZERO    = 7'h00;
  localparam logic [7:0] DUR_BYTE_ZERO   = 8'h00;
  // Identity codes: values are arbitrary
  localparam logic [7:0] DUR_REV_CODE    = 8'h01;
  localparam logic [7:0] DUR_DEV_ID      = 8'h5c;
  // Register bank selected by the line control value alone
  typedef enum logic [1:0] {
    DUR_BANK_STD = 2'b00,
    DUR_BANK_DIV = 2'b01,
    DUR_BANK_ENH = 2'b11
  } dur_bank_t;
  // Host bus pins as one sampled word
  typedef struct packed {
    logic       cs_n;
    logic       channel_pick;
    logic [2:0] addr;
    logic       rd_n;
    logic       wr_n;
    logic [7:0] data;
  } dur_host_bus_t;
  localparam dur_host_bus_t DUR_BUS_IDLE = '{cs_n: 1'b1, channel_pick: 1'b0,
    addr: 3'h0, rd_n: 1'b1, wr_n: 1'b1, data: 8'h00};
  // Writable state of one channel
  typedef struct packed {
    logic [7:0] line_control;
    logic [7:0] interrupt_enable;
    logic [7:0] fifo_control;
    logic [7:0] modem_control;
    logic [7:0] scratch_pad;
    logic [7:0] divisor_low;
    logic [7:0] divisor_high;
    logic [7:0] alternate_function;
    logic [7:0] fifo_trigger_level;
    logic [7:0] feature_control;
    logic [7:0] enhanced_function;
    logic [7:0] enhanced_mode_select;
    logic [7:0] xon_char_1;
    logic [7:0] xon_char_2;
    logic [7:0] xoff_char_1;
    logic [7:0] xoff_char_2;
  } dur_chan_regs_t;
  localparam dur_chan_regs_t DUR_REGS_RST = '{line_control: 8'h00,
    interrupt_enable: 8'h00, fifo_control: 8'h00, modem_control: 8'h00,
    scratch_pad: 8'hff, divisor_low: 8'h00, divisor_high: 8'h00,
    alternate_function: 8'h00, fifo_trigger_level: 8'h00,
    feature_control: 8'h00, enhanced_function: 8'h00,
    enhanced_mode_select: 8'h80, xon_char_1: 8'h00, xon_char_2: 8'h00,
    xoff_char_1: 8'h00, xoff_char_2: 8'h00};
  // Read-only status supplied by the channel's serial logic
  typedef struct packed {
    logic [7:0] rx_holding;
    logic [7:0] interrupt_status;
    logic [7:0] line_status;
    logic [7:0] modem_status;
  } dur_chan_status_t;
endpackage

// ### core/dur_sync.sv
// Two flip-flop synchroniser, one per bit.
// Assumes inputs are asynchronous levels; reset value per bit given.
`timescale 1ns/10ps
module dur_sync #(
  parameter int                 WIDTH = 1,
  parameter logic [WIDTH-1:0]   RST   = '0
) (
  // Clock and control
  input  wire logic             clk_in,
  input  wire logic             reset_n_in,
  input  wire logic             clk_en_in,
  // Data
  input  wire logic [WIDTH-1:0] d_in,
  output logic      [WIDTH-1:0] q_out
);
  for (genvar b = 0; b < WIDTH; b++) begin : g_bit
    logic s1_q;
    logic s2_q;
    // First stage feeds only the second
    always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
        s1_q <= RST[b];
        s2_q <= RST[b];
      end else if (clk_en_in) begin
        s1_q <= d_in[b];
        s2_q <= s1_q;
      end
    end
    assign q_out[b] = s2_q;
  end
endmodule // dur_sync

// ### core/dur_level_count.sv
// Receive and transmit FIFO fill counters with a selectable view.
// Assumes push, pop and clear are one-cycle pulses on the core clock.
`timescale 1ns/10ps
module dur_level_count (
  // Clock and control
  input  wire logic       clk_in,
  input  wire logic       reset_n_in,
  input  wire logic       clk_en_in,
  // Events
  input  wire logic       rx_push_in,
  input  wire logic       rx_pop_in,
  input  wire logic       rx_clr_in,
  input  wire logic       tx_push_in,
  input  wire logic       tx_pop_in,
  input  wire logic       tx_clr_in,
  input  wire logic       tx_view_in,
  // Level
  output logic      [7:0] level_out
);
  logic [6:0] rx_q, rx_d, tx_q, tx_d;

  // Saturating up/down count; clear has priority
  function automatic logic [6:0] step(input logic [6:0] c, input logic up,
                                      input logic dn, input logic clr);
    logic [6:0] n;
    n = c;
    if (clr) begin
      n = dur_pkg::DUR_LVL_ZERO;
    end else if (up && !dn && c != dur_pkg::DUR_FIFO_DEPTH) begin
      n = c + 7'h01;
    end else if (dn && !up && c != dur_pkg::DUR_LVL_ZERO) begin
      n = c - 7'h01;
    end
    return n;
  endfunction

  // Next counts
  always_comb begin
    rx_d = step(rx_q, rx_push_in, rx_pop_in, rx_clr_in);
    tx_d = step(tx_q, tx_push_in, tx_pop_in, tx_clr_in);
  end

  // Count registers
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      rx_q <= dur_pkg::DUR_LVL_ZERO;
      tx_q <= dur_pkg::DUR_LVL_ZERO;
    end else if (clk_en_in) begin
      rx_q <= rx_d;
      tx_q <= tx_d;
    end
  end

  assign level_out = {1'b0, tx_view_in ? tx_q : rx_q};
endmodule // dur_level_count

// ### core/dur_reg_select.sv
// Register select and bank decode for both channels of the dual UART.
// Assumes an asynchronous parallel host bus on pins; serial logic on the
// core clock supplies status and FIFO events and consumes the settings.
`timescale 1ns/10ps
module dur_reg_select (
  // Clock, reset and enable
  input  wire logic                       core_clk_in,
  input  wire logic                       reset_n_in,
  input  wire logic                       clk_en_in,
  // Host bus pins
  input  wire logic                       host_cs_n_in,
  input  wire logic                       channel_pick_in,
  input  wire logic [2:0]                 host_addr_in,
  input  wire logic                       host_rd_n_in,
  input  wire logic                       host_wr_n_in,
  input  wire logic [7:0]                 host_data_in,
  output logic      [7:0]                 host_data_out,
  output logic                            host_data_oe_out,
  // Per channel status and FIFO events from serial logic
  input  wire dur_pkg::dur_chan_status_t  status_in [2],
  input  wire logic [1:0]                 rx_push_in,
  input  wire logic [1:0]                 tx_pop_in,
  // Per channel settings and strobes to serial logic
  output dur_pkg::dur_chan_regs_t         cfg_out [2],
  output logic      [1:0]                 tx_load_out,
  output logic      [1:0]                 rx_take_out,
  output logic      [1:0]                 fifo_ctl_load_out,
  output logic      [7:0]                 wr_data_out
);
  dur_pkg::dur_host_bus_t bus_raw, bus_s, bus_q;
  dur_pkg::dur_chan_regs_t regs_q [2];
  logic [7:0] rd_mux [2];
  logic       wr_end, rd_end, rd_act;
  logic [7:0] rdata_q, rdata_d, wdat_q, wdat_d;
  logic       oe_q, oe_d;
  logic       concurrent;

  assign bus_raw = '{cs_n: host_cs_n_in, channel_pick: channel_pick_in,
                     addr: host_addr_in, rd_n: host_rd_n_in,
                     wr_n: host_wr_n_in, data: host_data_in};

  // Pin synchroniser for the whole host bus
  dur_sync #(
    .WIDTH ($bits(dur_pkg::dur_host_bus_t)),
    .RST   (dur_pkg::DUR_BUS_IDLE)
  ) u_sync (
    .clk_in     (core_clk_in),
    .reset_n_in (reset_n_in),
    .clk_en_in  (clk_en_in),
    .d_in       (bus_raw),
    .q_out      (bus_s)
  );

  // Strobe ends: writes and read side effects act as the strobe releases
  assign wr_end = !bus_q.cs_n && !bus_q.wr_n && bus_s.wr_n;
  assign rd_end = !bus_q.cs_n && !bus_q.rd_n && bus_s.rd_n;
  assign rd_act = !bus_s.cs_n && !bus_s.rd_n;
  assign concurrent = regs_q[0].alternate_function[dur_pkg::DUR_AF_CONC_BIT];

  for (genvar ch = 0; ch < dur_pkg::DUR_CHANNELS; ch++) begin : g_chan
    dur_pkg::dur_chan_regs_t r_d;
    dur_pkg::dur_bank_t      bank;
    logic [7:0]              level;
    logic                    picked, wr_hit, rd_hit;
    logic                    swap, div_zero;
    logic                    txl_d, txl_q, take_d, take_q, fcl_d, fcl_q;
    logic                    rx_clr, tx_clr;

    assign picked  = bus_q.channel_pick == 1'(ch);
    // Concurrent write lets one write reach both channels
    assign wr_hit  = wr_end && (picked || concurrent);
    assign rd_hit  = rd_end && picked;
    assign swap    = regs_q[ch].feature_control[dur_pkg::DUR_FT_SWAP_BIT];
    assign div_zero = regs_q[ch].divisor_low == dur_pkg::DUR_BYTE_ZERO &&
                      regs_q[ch].divisor_high == dur_pkg::DUR_BYTE_ZERO;

    // Bank from the current line control value
    always_comb begin
      if (regs_q[ch].line_control == dur_pkg::DUR_LC_ENH_KEY) begin
        bank = dur_pkg::DUR_BANK_ENH;
      end else if (regs_q[ch].line_control[dur_pkg::DUR_LC_DIV_BIT]) begin
        bank = dur_pkg::DUR_BANK_DIV;
      end else begin
        bank = dur_pkg::DUR_BANK_STD;
      end
    end

    // Read data for this channel at the current address
    always_comb begin
      rd_mux[ch] = status_in[ch].line_status;
      if (bus_s.addr == dur_pkg::DUR_A_3) begin
        rd_mux[ch] = regs_q[ch].line_control;
      end else if (bank == dur_pkg::DUR_BANK_ENH) begin
        case (bus_s.addr)
          dur_pkg::DUR_A_0: rd_mux[ch] = level;
          dur_pkg::DUR_A_1: rd_mux[ch] = regs_q[ch].feature_control;
          dur_pkg::DUR_A_2: rd_mux[ch] = regs_q[ch].enhanced_function;
          dur_pkg::DUR_A_4: rd_mux[ch] = regs_q[ch].xon_char_1;
          dur_pkg::DUR_A_5: rd_mux[ch] = regs_q[ch].xon_char_2;
          dur_pkg::DUR_A_6: rd_mux[ch] = regs_q[ch].xoff_char_1;
          default:          rd_mux[ch] = regs_q[ch].xoff_char_2;
        endcase
      end else if (bus_s.addr == dur_pkg::DUR_A_0) begin
        if (bank == dur_pkg::DUR_BANK_STD) begin
          rd_mux[ch] = status_in[ch].rx_holding;
        end else if (div_zero) begin
          rd_mux[ch] = dur_pkg::DUR_REV_CODE;
        end else begin
          rd_mux[ch] = regs_q[ch].divisor_low;
        end
      end else if (bus_s.addr == dur_pkg::DUR_A_1) begin
        if (bank == dur_pkg::DUR_BANK_STD) begin
          rd_mux[ch] = regs_q[ch].interrupt_enable;
        end else if (div_zero) begin
          rd_mux[ch] = dur_pkg::DUR_DEV_ID;
        end else begin
          rd_mux[ch] = regs_q[ch].divisor_high;
        end
      end else if (bus_s.addr == dur_pkg::DUR_A_2) begin
        if (bank == dur_pkg::DUR_BANK_DIV) begin
          rd_mux[ch] = regs_q[ch].alternate_function;
        end else begin
          rd_mux[ch] = status_in[ch].interrupt_status;
        end
      end else if (bus_s.addr == dur_pkg::DUR_A_4) begin
        rd_mux[ch] = regs_q[ch].modem_control;
      end else if (bus_s.addr == dur_pkg::DUR_A_6) begin
        rd_mux[ch] = status_in[ch].modem_status;
      end else if (bus_s.addr == dur_pkg::DUR_A_7) begin
        if (swap) begin
          rd_mux[ch] = level;
        end else begin
          rd_mux[ch] = regs_q[ch].scratch_pad;
        end
      end
    end

    // Next register values from a committed write
    always_comb begin
      r_d    = regs_q[ch];
      txl_d  = 1'b0;
      fcl_d  = 1'b0;
      take_d = rd_hit && bank == dur_pkg::DUR_BANK_STD &&
               bus_q.addr == dur_pkg::DUR_A_0;
      if (wr_hit) begin
        if (bus_q.addr == dur_pkg::DUR_A_3) begin
          r_d.line_control = bus_q.data;
        end else if (bank == dur_pkg::DUR_BANK_ENH) begin
          case (bus_q.addr)
            dur_pkg::DUR_A_0: r_d.fifo_trigger_level = bus_q.data;
            dur_pkg::DUR_A_1: r_d.feature_control = bus_q.data;
            dur_pkg::DUR_A_2: r_d.enhanced_function = bus_q.data;
            dur_pkg::DUR_A_4: r_d.xon_char_1 = bus_q.data;
            dur_pkg::DUR_A_5: r_d.xon_char_2 = bus_q.data;
            dur_pkg::DUR_A_6: r_d.xoff_char_1 = bus_q.data;
            default:          r_d.xoff_char_2 = bus_q.data;
          endcase
        end else if (bus_q.addr == dur_pkg::DUR_A_0) begin
          if (bank == dur_pkg::DUR_BANK_DIV) begin
            r_d.divisor_low = bus_q.data;
          end else begin
            txl_d = 1'b1;
          end
        end else if (bus_q.addr == dur_pkg::DUR_A_1) begin
          if (bank == dur_pkg::DUR_BANK_DIV) begin
            r_d.divisor_high = bus_q.data;
          end else begin
            r_d.interrupt_enable = bus_q.data;
          end
        end else if (bus_q.addr == dur_pkg::DUR_A_2) begin
          if (bank == dur_pkg::DUR_BANK_DIV) begin
            r_d.alternate_function = bus_q.data;
          end else begin
            r_d.fifo_control = bus_q.data;
            fcl_d = 1'b1;
          end
        end else if (bus_q.addr == dur_pkg::DUR_A_4) begin
          r_d.modem_control = bus_q.data;
        end else if (bus_q.addr == dur_pkg::DUR_A_7) begin
          if (swap) begin
            r_d.enhanced_mode_select = bus_q.data;
          end else begin
            r_d.scratch_pad = bus_q.data;
          end
        end
      end
    end

    // Channel registers and strobes
    always_ff @(posedge core_clk_in) begin
      if (!reset_n_in) begin
        regs_q[ch] <= dur_pkg::DUR_REGS_RST;
        txl_q      <= 1'b0;
        take_q     <= 1'b0;
        fcl_q      <= 1'b0;
      end else if (clk_en_in) begin
        regs_q[ch] <= r_d;
        txl_q      <= txl_d;
        take_q     <= take_d;
        fcl_q      <= fcl_d;
      end
    end

    // FIFO resets requested through the FIFO control write
    assign rx_clr = fcl_q && regs_q[ch].fifo_control[dur_pkg::DUR_RX_CLR_BIT];
    assign tx_clr = fcl_q && regs_q[ch].fifo_control[dur_pkg::DUR_TX_CLR_BIT];

    // FIFO level seen through both the enhanced and swapped views
    dur_level_count u_level (
      .clk_in     (core_clk_in),
      .reset_n_in (reset_n_in),
      .clk_en_in  (clk_en_in),
      .rx_push_in (rx_push_in[ch]),
      .rx_pop_in  (take_q),
      .rx_clr_in  (rx_clr),
      .tx_push_in (txl_q),
      .tx_pop_in  (tx_pop_in[ch]),
      .tx_clr_in  (tx_clr),
      .tx_view_in (regs_q[ch].feature_control[dur_pkg::DUR_FT_MODE_BIT]),
      .level_out  (level)
    );

    assign cfg_out[ch]           = regs_q[ch];
    assign tx_load_out[ch]       = txl_q;
    assign rx_take_out[ch]       = take_q;
    assign fifo_ctl_load_out[ch] = fcl_q;
  end

  // Bus-side next values: read data, drive enable, write data
  always_comb begin
    rdata_d = rdata_q;
    oe_d    = rd_act;
    wdat_d  = wdat_q;
    if (rd_act) begin
      rdata_d = rd_mux[bus_s.channel_pick];
    end
    if (wr_end) begin
      wdat_d = bus_q.data;
    end
  end

  // Bus-side registers and previous synchronised bus word
  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      bus_q   <= dur_pkg::DUR_BUS_IDLE;
      rdata_q <= dur_pkg::DUR_BYTE_ZERO;
      oe_q    <= 1'b0;
      wdat_q  <= dur_pkg::DUR_BYTE_ZERO;
    end else if (clk_en_in) begin
      bus_q   <= bus_s;
      rdata_q <= rdata_d;
      oe_q    <= oe_d;
      wdat_q  <= wdat_d;
    end
  end

  assign host_data_out    = rdata_q;
  assign host_data_oe_out = oe_q;
  assign wr_data_out      = wdat_q;
endmodule // dur_reg_select

// ### bench/dur_reg_select_props.sv
// Checker for the register select block, bound to its top ports.
// Assumes the host holds select, address and data steady across each strobe.
`timescale 1ns/10ps
module dur_reg_select_props (
  // Clock and reset
  input wire logic                    core_clk_in,
  input wire logic                    reset_n_in,
  // Host pins
  input wire logic                    host_cs_n_in,
  input wire logic                    channel_pick_in,
  input wire logic [2:0]              host_addr_in,
  input wire logic                    host_rd_n_in,
  input wire logic [7:0]              host_data_in,
  input wire logic [7:0]              host_data_out,
  input wire logic                    host_data_oe_out,
  // Settings and strobes
  input wire dur_pkg::dur_chan_regs_t cfg_out [2],
  input wire logic [1:0]              tx_load_out,
  input wire logic [1:0]              rx_take_out,
  input wire logic [1:0]              fifo_ctl_load_out,
  input wire logic [7:0]              wr_data_out
);
  logic [2:0]              rd_cnt_d;
  logic [2:0]              rd_cnt_q;
  dur_pkg::dur_chan_regs_t c;
  logic                    rd_ok;
  logic                    div_bank;
  logic                    div_zero;
  // Consecutive cycles of a selected read, saturating
  always_comb begin
    rd_cnt_d = (host_rd_n_in || host_cs_n_in) ? 3'h0 : ((rd_cnt_q == 3'h7) ? rd_cnt_q : rd_cnt_q + 3'h1);
  end
  always_ff @(posedge core_clk_in) begin
    rd_cnt_q <= reset_n_in ? rd_cnt_d : 3'h0;
  end
  // Settled read and bank view of the picked channel
  assign c        = cfg_out[channel_pick_in];
  assign rd_ok    = !host_rd_n_in && !host_cs_n_in && (rd_cnt_q >= 3'h4);
  assign div_bank = c.line_control[7] && (c.line_control != 8'hbf);
  assign div_zero = (c.divisor_low == 8'h00) && (c.divisor_high == 8'h00);

  a_read_drives_bus: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    rd_ok |-> host_data_oe_out) else $error("bus not driven in read");
  a_idle_bus_free: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    host_rd_n_in [*6] |-> !host_data_oe_out) else $error("bus driven while idle");
  a_ident_codes: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    rd_ok && div_bank && div_zero && (host_addr_in[2:1] == 2'b00)
    |-> host_data_out == (host_addr_in[0] ? dur_pkg::DUR_DEV_ID : dur_pkg::DUR_REV_CODE))
    else $error("identity read wrong");
  a_divisor_high: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    rd_ok && div_bank && !div_zero && (host_addr_in == 3'h1) |-> host_data_out == c.divisor_high)
    else $error("divisor high read wrong");
  a_scratch_read: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    rd_ok && (c.line_control != 8'hbf) && !c.feature_control[6] && (host_addr_in == 3'h7)
    |-> host_data_out == c.scratch_pad) else $error("scratch read wrong");
  a_feature_read: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    rd_ok && (c.line_control == 8'hbf) && (host_addr_in == 3'h1) |-> host_data_out == c.feature_control)
    else $error("feature read wrong");
  a_tx_load_data: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    (tx_load_out != 2'b00) |-> (wr_data_out == host_data_in) && (host_addr_in == 3'h0) && !host_cs_n_in)
    else $error("transmit load wrong");
  a_chan_isolate: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    $changed(cfg_out[1]) |-> $past(channel_pick_in) || $past(cfg_out[0].alternate_function[0]))
    else $error("channel one changed by channel zero");
  a_reset_values: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    $rose(reset_n_in) |-> (cfg_out[0].scratch_pad == 8'hff) && (cfg_out[1].enhanced_mode_select == 8'h80))
    else $error("reset values wrong");
  a_rx_take_std: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    (rx_take_out != 2'b00) |-> rx_take_out[channel_pick_in] && host_rd_n_in && (host_addr_in == 3'h0)
    && !c.line_control[7]) else $error("receive take wrong");
  a_fifo_ctl_load: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    (fifo_ctl_load_out != 2'b00) |-> (host_addr_in == 3'h2)
    && (!fifo_ctl_load_out[0] || (wr_data_out == cfg_out[0].fifo_control))
    && (!fifo_ctl_load_out[1] || (wr_data_out == cfg_out[1].fifo_control)))
    else $error("fifo control load wrong");
endmodule // dur_reg_select_props

bind dur_reg_select dur_reg_select_props u_props (
  .core_clk_in(core_clk_in), .reset_n_in(reset_n_in), .host_cs_n_in(host_cs_n_in),
  .channel_pick_in(channel_pick_in), .host_addr_in(host_addr_in), .host_rd_n_in(host_rd_n_in),
  .host_data_in(host_data_in), .host_data_out(host_data_out), .host_data_oe_out(host_data_oe_out),
  .cfg_out(cfg_out), .tx_load_out(tx_load_out), .wr_data_out(wr_data_out),
  .rx_take_out(rx_take_out), .fifo_ctl_load_out(fifo_ctl_load_out)
);

// ### bench/dur_host_model.sv
// Host processor model driving the parallel register bus pins.
// Assumes pins change at the falling edge; read data is taken at a rising edge.
`timescale 1ns/10ps
module dur_host_model (
  // Clock
  input  wire logic             clk_in,
  // Host bus pins
  output dur_pkg::dur_host_bus_t bus_out,
  input  wire logic [7:0]       data_in,
  input  wire logic             oe_in,
  // Read results
  output logic                  got_out,
  output logic [7:0]            got_data_out
);
  // Idle bus at time zero
  initial begin
    bus_out = dur_pkg::DUR_BUS_IDLE;
    got_out = 1'b0;
    got_data_out = 8'h00;
  end
  // Write: select, strobe, hold fields after release, then deselect and drive inverted data
  task automatic wr(input logic ch, input logic [2:0] a, input logic [7:0] d);
    @(negedge clk_in);
    bus_out = '{cs_n: 1'b0, channel_pick: ch, addr: a, rd_n: 1'b1, wr_n: 1'b1, data: d};
    @(negedge clk_in);
    bus_out.wr_n = 1'b0;
    repeat (3) @(negedge clk_in);
    bus_out.wr_n = 1'b1;
    repeat (5) @(negedge clk_in);
    bus_out.cs_n = 1'b1;
    bus_out.data = ~d;
    repeat (3) @(negedge clk_in);
  endtask
  // Read: wait for the bus to be driven, take data two edges later
  task automatic rd(input logic ch, input logic [2:0] a);
    int n;
    @(negedge clk_in);
    bus_out.cs_n = 1'b0;
    bus_out.channel_pick = ch;
    bus_out.addr = a;
    @(negedge clk_in);
    bus_out.rd_n = 1'b0;
    n = 0;
    while (oe_in !== 1'b1 && n < 20) begin
      @(negedge clk_in);
      n++;
    end
    repeat (2) @(posedge clk_in);
    got_data_out <= data_in;
    got_out <= 1'b1;
    @(negedge clk_in);
    got_out = 1'b0;
    bus_out.rd_n = 1'b1;
    repeat (3) @(negedge clk_in);
    bus_out.cs_n = 1'b1;
    repeat (3) @(negedge clk_in);
  endtask
endmodule // dur_host_model

// ### bench/testbench.sv
// Self-checking bench for the register select block.
// Assumes the host model drives the pins and the bench plays the serial side.
`timescale 1ns/10ps
module testbench;
  logic                    core_clk;
  logic                    reset_n;
  logic                    clk_en;
  dur_pkg::dur_host_bus_t  bus;
  logic [7:0]              dout;
  logic                    oe;
  dur_pkg::dur_chan_status_t status [2];
  logic [1:0]              rx_push;
  logic [1:0]              tx_pop;
  dur_pkg::dur_chan_regs_t cfg [2];
  logic                    got;
  logic [7:0]              got_data;
  logic [7:0]              exp_q [$];
  logic [7:0]              r0;
  logic [7:0]              r1;
  int                      bad_count;
  int                      checked;

  dur_reg_select dut (
    .core_clk_in(core_clk), .reset_n_in(reset_n), .clk_en_in(clk_en), .host_cs_n_in(bus.cs_n),
    .channel_pick_in(bus.channel_pick), .host_addr_in(bus.addr), .host_rd_n_in(bus.rd_n),
    .host_wr_n_in(bus.wr_n), .host_data_in(bus.data), .host_data_out(dout), .host_data_oe_out(oe),
    .status_in(status), .rx_push_in(rx_push), .tx_pop_in(tx_pop), .cfg_out(cfg),
    .tx_load_out(), .rx_take_out(), .fifo_ctl_load_out(), .wr_data_out()
  );
  dur_host_model host (
    .clk_in(core_clk), .bus_out(bus), .data_in(dout), .oe_in(oe), .got_out(got), .got_data_out(got_data)
  );
  // Clock
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  // Compare one value
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Note the expected result, then read
  task automatic rd_exp(input logic ch, input logic [2:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    host.rd(ch, a);
  endtask
  // Serial side event pulses
  task automatic pulse_ev(input logic [1:0] rx, input logic [1:0] tx);
    @(negedge core_clk);
    rx_push = rx;
    tx_pop = tx;
    @(negedge core_clk);
    rx_push = 2'b00;
    tx_pop = 2'b00;
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Oldest note against each read result
  always @(posedge got) begin
    chk("read data", exp_q.pop_front(), got_data);
  end
  // Watchdog
  initial begin
    repeat (20000) @(posedge core_clk);
    bad_count++;
    report_and_stop();
  end
  // Main sequence
  initial begin
    r0 = $urandom(32'hffc0);
    for (int i = 0; i < 2; i++) begin
      status[i] = dur_pkg::dur_chan_status_t'($urandom());
    end
    reset_n = 1'b0;
    clk_en = 1'b1;
    rx_push = 2'b00;
    tx_pop = 2'b00;
    repeat (4) @(negedge core_clk);
    reset_n = 1'b1;
    repeat (2) @(negedge core_clk);
    // Reset values and status view of both channels
    for (int ch = 0; ch < 2; ch++) begin
      rd_exp(ch[0], 3'h0, status[ch].rx_holding);
      rd_exp(ch[0], 3'h1, 8'h00);
      rd_exp(ch[0], 3'h2, status[ch].interrupt_status);
      rd_exp(ch[0], 3'h3, 8'h00);
      rd_exp(ch[0], 3'h5, status[ch].line_status);
      rd_exp(ch[0], 3'h6, status[ch].modem_status);
      rd_exp(ch[0], 3'h7, 8'hff);
    end
    // Independent scratch registers
    r0 = $urandom();
    r1 = $urandom();
    host.wr(1'b0, 3'h7, r0);
    host.wr(1'b1, 3'h7, r1);
    rd_exp(1'b0, 3'h7, r0);
    rd_exp(1'b1, 3'h7, r1);
    // Divisor bank, identity codes while both bytes are zero
    host.wr(1'b0, 3'h3, 8'h80);
    rd_exp(1'b0, 3'h0, dur_pkg::DUR_REV_CODE);
    rd_exp(1'b0, 3'h1, dur_pkg::DUR_DEV_ID);
    host.wr(1'b0, 3'h0, r1 | 8'h01);
    rd_exp(1'b0, 3'h0, r1 | 8'h01);
    rd_exp(1'b0, 3'h1, 8'h00);
    host.wr(1'b0, 3'h2, 8'h06);
    rd_exp(1'b0, 3'h2, 8'h06);
    rd_exp(1'b0, 3'h7, r0);
    // Concurrent write reaches channel one as well
    host.wr(1'b0, 3'h2, 8'h07);
    host.wr(1'b0, 3'h7, r0 ^ 8'h5a);
    rd_exp(1'b1, 3'h7, r0 ^ 8'h5a);
    host.wr(1'b0, 3'h2, 8'h06);
    // Enhanced bank hides the divisor bank
    host.wr(1'b0, 3'h3, 8'hbf);
    for (int a = 1; a < 8; a++) begin
      if (a != 3) begin
        r1 = $urandom();
        host.wr(1'b0, a[2:0], r1);
        rd_exp(1'b0, a[2:0], r1);
      end
    end
    host.wr(1'b0, 3'h0, r0);
    chk("trigger level", r0, cfg[0].fifo_trigger_level);
    rd_exp(1'b0, 3'h0, 8'h00);
    // Receive level through both views
    host.wr(1'b0, 3'h1, 8'h40);
    repeat (3) pulse_ev(2'b01, 2'b00);
    rd_exp(1'b0, 3'h0, 8'h03);
    host.wr(1'b0, 3'h3, 8'h03);
    rd_exp(1'b0, 3'h7, 8'h03);
    // FIFO control write clears the receive level
    host.wr(1'b0, 3'h2, 8'h02);
    rd_exp(1'b0, 3'h7, 8'h00);
    r1 = $urandom();
    host.wr(1'b0, 3'h7, r1);
    chk("mode select", r1, cfg[0].enhanced_mode_select);
    // Transmit level: load one, pop one
    host.wr(1'b0, 3'h3, 8'hbf);
    host.wr(1'b0, 3'h1, 8'hc0);
    host.wr(1'b0, 3'h3, 8'h03);
    host.wr(1'b0, 3'h0, r0);
    rd_exp(1'b0, 3'h7, 8'h01);
    pulse_ev(2'b00, 2'b01);
    rd_exp(1'b0, 3'h7, 8'h00);
    // Frozen clock enable drops a whole write
    clk_en = 1'b0;
    host.wr(1'b0, 3'h0, r0);
    clk_en = 1'b1;
    rd_exp(1'b0, 3'h7, 8'h00);
    repeat (10) @(negedge core_clk);
    report_and_stop();
  end
endmodule // testbench
